// ===== verilog/adcb_defs.svh
// Purpose: Named offsets, fields, codes and timing counts of the channel B output block.
// Assumes: Word-wide Wishbone access; register index is byte address divided by four.
// Notes:   Definitions only.
`ifndef ADCB_DEFS_SVH
`define ADCB_DEFS_SVH

// ============================================================
// Register indices
`define ADCB_IDX_CUST_LO      8'h51
`define ADCB_IDX_CUST_HI      8'h52
`define ADCB_IDX_OFS_EN_COM   8'h53
`define ADCB_IDX_PAT_COM      8'h62
`define ADCB_IDX_PED_COM      8'h63
`define ADCB_IDX_OFS_EN_B     8'h66
`define ADCB_IDX_PAT_B        8'h75
`define ADCB_IDX_PED_B        8'h76
`define ADCB_IDX_CTRL         8'h40
`define ADCB_IDX_STAT         8'h41

// ============================================================
// Field positions
`define ADCB_PAT_MSB          2
`define ADCB_PAT_LSB          0
`define ADCB_PED_MSB          5
`define ADCB_PED_LSB          3
`define ADCB_OFS_EN_BIT       6
`define ADCB_CTRL_INDEP_BIT   0
`define ADCB_CTRL_DDR_BIT     1
`define ADCB_CTRL_TWOS_BIT    2

// ============================================================
// Codes and counts
`define ADCB_PAT_NORMAL       3'h0
`define ADCB_PAT_ZEROS        3'h1
`define ADCB_PAT_ONES         3'h2
`define ADCB_PAT_TOGGLE       3'h3
`define ADCB_PAT_RAMP         3'h4
`define ADCB_PAT_CUSTOM       3'h5
`define ADCB_TOGGLE_A         11'h2aa
`define ADCB_TOGGLE_B         11'h555
`define ADCB_MIDCODE          12'sh400
`define ADCB_RAMP_STEP_CYC    3'h7
`define ADCB_LATENCY          22
`define ADCB_DATA_MSB         10
`define ADCB_REG_RESET        8'h00

`endif

// ===== verilog/adcb_pkg.sv
// Purpose: Types shared by the channel B output block.
// Assumes: Constants come from adcb_defs.svh.
// Notes:   Types only.
`default_nettype none
package adcb_pkg;

    // ============================================================
    // Test pattern selection
    typedef enum logic [2:0] {
        ADCB_PS_NORMAL = 3'b000,
        ADCB_PS_ZEROS  = 3'b001,
        ADCB_PS_ONES   = 3'b010,
        ADCB_PS_TOGGLE = 3'b011,
        ADCB_PS_RAMP   = 3'b100,
        ADCB_PS_CUSTOM = 3'b101,
        ADCB_PS_UNU6   = 3'b110,
        ADCB_PS_UNU7   = 3'b111
    } adcb_pat_t;

    // ============================================================
    // Wishbone request and answer
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [31:0] adr;
        logic [31:0] dat;
    } adcb_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } adcb_wb_rsp_t;

    // ============================================================
    // Output sample carrier
    typedef struct packed {
        logic [11:0] word;
        logic [5:0]  ddr_half;
        logic        clk;
    } adcb_out_t;

endpackage
`default_nettype wire

// ===== verilog/adcb_top.sv
// Purpose: Channel B output side: test patterns, pedestal, offset loop, latency, coding.
// Assumes: clk_i at 250 MHz; sampling clock and converter code arrive asynchronously.
// Notes:   One sample per falling edge of the synchronised sampling clock.
// Notes on behaviour
// - Codes 000/001/010 give normal, zeros, ones.
// - Code 011 alternates 01010101010 and 10101010101.
// - Code 100 ramps up one LSB per eight.
// - Code 101 outputs the custom register word.
// - Double data rate sends twelve bits, dummy first.
// - Normal conversion drives dummy bit as zero.
// - Channel B select only under independent control.
// - Offset loop converges to 1024 plus pedestal.
// - Pedestal is signed three bits at 5:3.
// - Channel B pedestal only under independent control.
// - Sample on each falling sampling clock edge.
// - Output appears 22 sample cycles after capture.
// - Parallel or double rate, offset or two's complement.
// - Eleven bit codes at full sample rate.
// - Enabled loop estimates and corrects every sample.
// - Disabled loop freezes and keeps last estimate.
`include "adcb_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module adcb_top (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire adcb_pkg::adcb_wb_req_t wb_req_i,
    output adcb_pkg::adcb_wb_rsp_t     wb_rsp_o,
    input  wire logic                  smp_clk_i,
    input  wire logic [10:0]           conv_code_i,
    output adcb_pkg::adcb_out_t        samp_out_o
);
    import adcb_pkg::*;

    // ============================================================
    // Register file
    logic [7:0]  cust_lo_q;
    logic [7:0]  cust_hi_q;
    logic [7:0]  ofs_en_com_q;
    logic [7:0]  pat_com_q;
    logic [7:0]  ped_com_q;
    logic [7:0]  ofs_en_b_q;
    logic [7:0]  pat_b_q;
    logic [7:0]  ped_b_q;
    logic [7:0]  ctrl_q;
    logic        ack_q;
    logic [31:0] rdat_q;
    logic [7:0]  idx;
    logic        wr_en;
    logic [31:0] rd_mux;
    logic [11:0] est_q;

    assign idx   = wb_req_i.adr[9:2];
    // The write lands at the edge where the master sees ack, not at the request edge.
    assign wr_en = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && ack_q && wb_req_i.sel[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cust_lo_q    <= `ADCB_REG_RESET;
            cust_hi_q    <= `ADCB_REG_RESET;
            ofs_en_com_q <= `ADCB_REG_RESET;
            pat_com_q    <= `ADCB_REG_RESET;
            ped_com_q    <= `ADCB_REG_RESET;
            ofs_en_b_q   <= `ADCB_REG_RESET;
            pat_b_q      <= `ADCB_REG_RESET;
            ped_b_q      <= `ADCB_REG_RESET;
            ctrl_q       <= `ADCB_REG_RESET;
        end else if (wr_en) begin
            case (idx)
                `ADCB_IDX_CUST_LO:    cust_lo_q    <= wb_req_i.dat[7:0];
                `ADCB_IDX_CUST_HI:    cust_hi_q    <= wb_req_i.dat[7:0];
                `ADCB_IDX_OFS_EN_COM: ofs_en_com_q <= wb_req_i.dat[7:0];
                `ADCB_IDX_PAT_COM:    pat_com_q    <= wb_req_i.dat[7:0];
                `ADCB_IDX_PED_COM:    ped_com_q    <= wb_req_i.dat[7:0];
                `ADCB_IDX_OFS_EN_B:   ofs_en_b_q   <= wb_req_i.dat[7:0];
                `ADCB_IDX_PAT_B:      pat_b_q      <= wb_req_i.dat[7:0];
                `ADCB_IDX_PED_B:      ped_b_q      <= wb_req_i.dat[7:0];
                `ADCB_IDX_CTRL:       ctrl_q       <= wb_req_i.dat[7:0];
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (idx)
            `ADCB_IDX_CUST_LO:    rd_mux[7:0]  = cust_lo_q;
            `ADCB_IDX_CUST_HI:    rd_mux[7:0]  = cust_hi_q;
            `ADCB_IDX_OFS_EN_COM: rd_mux[7:0]  = ofs_en_com_q;
            `ADCB_IDX_PAT_COM:    rd_mux[7:0]  = pat_com_q;
            `ADCB_IDX_PED_COM:    rd_mux[7:0]  = ped_com_q;
            `ADCB_IDX_OFS_EN_B:   rd_mux[7:0]  = ofs_en_b_q;
            `ADCB_IDX_PAT_B:      rd_mux[7:0]  = pat_b_q;
            `ADCB_IDX_PED_B:      rd_mux[7:0]  = ped_b_q;
            `ADCB_IDX_CTRL:       rd_mux[7:0]  = ctrl_q;
            `ADCB_IDX_STAT:       rd_mux[11:0] = est_q;
            default:              rd_mux       = 32'h0000_0000;
        endcase
    end

    // Single wait state; unmapped indices answer with zero and ignore writes.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q  <= wb_req_i.cyc && wb_req_i.stb && !ack_q;
            rdat_q <= rd_mux;
        end
    end

    assign wb_rsp_o.ack = ack_q;
    assign wb_rsp_o.dat = rdat_q;

    // ============================================================
    // Effective settings
    logic        indep;
    logic        ddr_mode;
    logic        twos_mode;
    adcb_pat_t   pat_sel;
    logic [2:0]  ped_field;
    logic        ofs_en;
    logic [11:0] target;

    assign indep     = ctrl_q[`ADCB_CTRL_INDEP_BIT];
    assign ddr_mode  = ctrl_q[`ADCB_CTRL_DDR_BIT];
    assign twos_mode = ctrl_q[`ADCB_CTRL_TWOS_BIT];
    // Without independent control channel B mirrors the common settings.
    assign pat_sel   = adcb_pat_t'(indep ? pat_b_q[`ADCB_PAT_MSB:`ADCB_PAT_LSB]
                                         : pat_com_q[`ADCB_PAT_MSB:`ADCB_PAT_LSB]);
    assign ped_field = indep ? ped_b_q[`ADCB_PED_MSB:`ADCB_PED_LSB]
                             : ped_com_q[`ADCB_PED_MSB:`ADCB_PED_LSB];
    assign ofs_en    = indep ? ofs_en_b_q[`ADCB_OFS_EN_BIT] : ofs_en_com_q[`ADCB_OFS_EN_BIT];
    // Sign-extend the three-bit pedestal onto mid-code.
    assign target    = `ADCB_MIDCODE + {{9{ped_field[2]}}, ped_field};

    // ============================================================
    // Sampling clock and code synchronisers
    logic        sclk_m_q;
    logic        sclk_s_q;
    logic        sclk_d_q;
    logic [10:0] code_m_q;
    logic [10:0] code_s_q;
    logic        smp_ev;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sclk_m_q <= 1'b0;
            sclk_s_q <= 1'b0;
            sclk_d_q <= 1'b0;
            code_m_q <= 11'h000;
            code_s_q <= 11'h000;
        end else begin
            sclk_m_q <= smp_clk_i;
            sclk_s_q <= sclk_m_q;
            sclk_d_q <= sclk_s_q;
            code_m_q <= conv_code_i;
            code_s_q <= code_m_q;
        end
    end

    // Both channels sample together on the falling edge; only B is kept here.
    assign smp_ev = sclk_d_q && !sclk_s_q;

    // ============================================================
    // Offset correction loop
    logic [11:0] corrected;
    logic [11:0] capt_q;

    // A one-LSB step per sample trades settling time for a tiny gate count.
    assign corrected = {1'b0, code_s_q} - est_q + `ADCB_MIDCODE - `ADCB_MIDCODE;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            est_q <= 12'h000;
        end else if (smp_ev && ofs_en) begin
            if ($signed(corrected) > $signed(target)) begin
                est_q <= est_q + 12'h001;
            end else if ($signed(corrected) < $signed(target)) begin
                est_q <= est_q - 12'h001;
            end
        end
        // Disabled: the estimate holds and is still subtracted below.
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            capt_q <= 12'h000;
        end else if (smp_ev) begin
            capt_q <= corrected;
        end
    end

    // ============================================================
    // Fixed latency pipeline
    logic [10:0] pipe_q [0:`ADCB_LATENCY-1];
    logic [10:0] clipped;

    // Saturate so a large estimate cannot wrap the code.
    always_comb begin
        clipped = capt_q[10:0];
        if (capt_q[11]) begin
            // Twelve bits cannot tell overflow from underflow, so the estimate's sign decides.
            clipped = est_q[11] ? 11'h7ff : 11'h000;
        end
    end

    // The output register adds one sample after the pipe tap, so 21 stages give 22.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < `ADCB_LATENCY; i++) begin
                pipe_q[i] <= 11'h000;
            end
        end else if (smp_ev) begin
            pipe_q[0] <= clipped;
            for (int i = 1; i < `ADCB_LATENCY; i++) begin
                pipe_q[i] <= pipe_q[i-1];
            end
        end
    end

    // ============================================================
    // Test pattern generators
    logic        tog_q;
    logic [2:0]  ramp_div_q;
    logic [10:0] ramp_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tog_q <= 1'b0;
        end else if (smp_ev) begin
            tog_q <= !tog_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || pat_sel != ADCB_PS_RAMP) begin
            ramp_div_q <= 3'h0;
            ramp_q     <= 11'h000;
        end else if (smp_ev) begin
            ramp_div_q <= ramp_div_q + 3'h1;
            if (ramp_div_q == `ADCB_RAMP_STEP_CYC) begin
                ramp_q <= ramp_q + 11'h001;
            end
        end
    end

    // ============================================================
    // Output word selection and coding
    logic [11:0] word_d;
    logic [11:0] word_q;
    logic [10:0] normal;

    // Two's complement is offset binary with the sign bit inverted.
    assign normal = twos_mode ? {!pipe_q[`ADCB_LATENCY-2][10], pipe_q[`ADCB_LATENCY-2][9:0]}
                              : pipe_q[`ADCB_LATENCY-2];

    always_comb begin
        word_d = {normal, 1'b0};
        case (pat_sel)
            ADCB_PS_NORMAL: word_d = {normal, 1'b0};
            ADCB_PS_ZEROS:  word_d = 12'h000;
            ADCB_PS_ONES:   word_d = 12'hfff;
            ADCB_PS_TOGGLE: word_d = {tog_q ? `ADCB_TOGGLE_B : `ADCB_TOGGLE_A, 1'b0};
            ADCB_PS_RAMP:   word_d = {ramp_q, 1'b0};
            ADCB_PS_CUSTOM: word_d = {cust_hi_q, cust_lo_q[7:4]};
            default:        word_d = {normal, 1'b0};
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            word_q <= 12'h000;
        end else if (smp_ev) begin
            word_q <= word_d;
        end
    end

    // ============================================================
    // Output stage
    logic       oclk_q;
    logic [5:0] half_q;
    logic [5:0] even_bits;
    logic [5:0] odd_bits;

    assign even_bits = {word_q[10], word_q[8], word_q[6], word_q[4], word_q[2], word_q[0]};
    assign odd_bits  = {word_q[11], word_q[9], word_q[7], word_q[5], word_q[3], word_q[1]};

    // Output clock is the inverted sampling clock; even bits, dummy included, on high.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oclk_q <= 1'b0;
            half_q <= 6'h00;
        end else begin
            oclk_q <= !sclk_s_q;
            if (!ddr_mode) begin
                half_q <= 6'h00;
            end else if (!sclk_s_q) begin
                half_q <= even_bits;
            end else begin
                half_q <= odd_bits;
            end
        end
    end

    // The capture side drops bit zero and keeps the eleven above it.
    assign samp_out_o.word     = word_q;
    assign samp_out_o.ddr_half = half_q;
    assign samp_out_o.clk      = oclk_q;

endmodule
`default_nettype wire

// ===== dv/adcb_assertions.sv
// Purpose: Port checks of the channel B output block.
// Assumes: Config is shadowed from acked Wishbone writes.
// Notes:   Patterns are judged only once config has stood 255 cycles.
`include "adcb_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module adcb_assertions (
    input wire logic                   clk_i,
    input wire logic                   rst_i,
    input wire adcb_pkg::adcb_wb_req_t wb_req_i,
    input wire adcb_pkg::adcb_wb_rsp_t wb_rsp_o,
    input wire logic                   smp_clk_i,
    input wire adcb_pkg::adcb_out_t    samp_out_o
);
    import adcb_pkg::*;
    logic        ind_q, sp_q, st, wr;
    logic [2:0]  pc_q, pb_q;
    logic [7:0]  age_q;
    logic [5:0]  fh_q;
    logic [10:0] w;
    adcb_pat_t   p;
    assign wr = wb_rsp_o.ack & wb_req_i.we & wb_req_i.sel[0];
    assign p  = adcb_pat_t'(ind_q ? pb_q : pc_q);
    assign st = age_q == 8'hff;
    assign w  = samp_out_o.word[11:1];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ind_q <= 1'b0;
            pc_q  <= 3'h0;
            pb_q  <= 3'h0;
        end else if (wr) begin
            case (wb_req_i.adr[9:2])
                `ADCB_IDX_CTRL: ind_q <= wb_req_i.dat[0];
                `ADCB_IDX_PAT_COM: pc_q <= wb_req_i.dat[2:0];
                `ADCB_IDX_PAT_B: pb_q <= wb_req_i.dat[2:0];
                default: ;
            endcase
        end
    end
    // A fresh write restarts the wait, since the output pipe still holds old words.
    always_ff @(posedge clk_i) begin
        if (rst_i || wr) begin
            age_q <= 8'h00;
        end else if (!st) begin
            age_q <= age_q + 8'h01;
        end
    end
    always_ff @(posedge clk_i) begin
        sp_q <= smp_clk_i;
        fh_q <= {fh_q[4:0], sp_q & ~smp_clk_i};
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    a_ack_latency: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack |=> wb_rsp_o.ack)
        else $error("ack late");
    a_ack_pulse: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
        else $error("ack too long");
    a_word_timing: assert property ($changed(samp_out_o.word) |-> |fh_q)
        else $error("word moved off a sample edge");
    a_zeros_word: assert property (st && p == ADCB_PS_ZEROS |-> samp_out_o.word == 12'h000)
        else $error("zeros pattern wrong");
    a_ones_word: assert property (st && p == ADCB_PS_ONES |-> w == 11'h7ff)
        else $error("ones pattern wrong");
    a_dummy_zero: assert property (st && (p == ADCB_PS_NORMAL || p[2:1] == 2'h3) |-> !samp_out_o.word[0])
        else $error("dummy bit set");
    a_toggle_alt: assert property (st && p == ADCB_PS_TOGGLE && $changed(w) |-> w == ~$past(w))
        else $error("toggle pattern wrong");
    a_ramp_step: assert property (st && p == ADCB_PS_RAMP && $changed(w) |-> w == $past(w) + 11'h001)
        else $error("ramp step wrong");
    c_toggle: cover property (st && p == ADCB_PS_TOGGLE && $changed(w));
    c_ramp: cover property (st && p == ADCB_PS_RAMP && $changed(w));
    c_read: cover property (wb_rsp_o.ack && !wb_req_i.we);
endmodule
bind adcb_top adcb_assertions i_adcb_assertions (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
    .wb_rsp_o(wb_rsp_o), .smp_clk_i(smp_clk_i), .samp_out_o(samp_out_o));
`default_nettype wire

// ===== dv/adcb_capture_model.sv
// Purpose: Capture logic at the far side of the sample link.
// Assumes: Output clock is slow against clk_i.
// Notes:   Takes a word at each falling output clock edge, mid-sample.
`timescale 1ns/1ps
`default_nettype none
module adcb_capture_model (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire adcb_pkg::adcb_out_t samp_i,
    output logic [10:0]              data_o,
    output logic                     valid_o
);
    import adcb_pkg::*;
    logic ck_q;
    always_ff @(posedge clk_i) begin
        ck_q    <= samp_i.clk;
        valid_o <= !rst_i && ck_q && !samp_i.clk;
        data_o  <= samp_i.word[11:1];
    end
endmodule
`default_nettype wire

// ===== dv/adcb_top_tb_top.sv
// Purpose: Self-checking bench of the channel B output block.
// Assumes: The 32 ns sampling clock runs free, unrelated to clk.
// Notes:   Read data and captured samples are checked against queues.
`include "adcb_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module adcb_top_tb_top;
    import adcb_pkg::*;
    logic         clk, rst, smp, cv, sp;
    logic [10:0]  code, cd, a, b;
    logic [15:0]  lf;
    logic [7:0]   ix_t [5];
    adcb_wb_req_t req;
    adcb_wb_rsp_t rsp;
    adcb_out_t    so;
    logic [31:0]  rq [$];
    logic [10:0]  sq [$];
    int           mismatches, checked, f, n;
    adcb_top i_adcb_top (.clk_i(clk), .rst_i(rst), .wb_req_i(req), .wb_rsp_o(rsp),
        .smp_clk_i(smp), .conv_code_i(code), .samp_out_o(so));
    adcb_capture_model i_adcb_capture_model (.clk_i(clk), .rst_i(rst), .samp_i(so),
        .data_o(cd), .valid_o(cv));
    always #2 clk = ~clk;
    initial begin
        smp = 1'b0;
        #1.3;
        forever #16 smp = ~smp;
    end
    function automatic logic [15:0] nx(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic final_report();
        if (mismatches == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic stop();
        mismatches++;
        final_report();
    endtask
    task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic chk_smp(input logic [10:0] e, input logic [10:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value sample exp %h got %h", e, g);
        end
    endtask
    // The request stands until ack is seen, so the monitor still sees we at that edge.
    task automatic wb(input logic [7:0] ix, input logic we, input logic [7:0] d);
        int k;
        req <= '{1'b1, 1'b1, we, 4'hf, {22'h0, ix, 2'h0}, {24'h0, d}};
        for (k = 0; k < 64; k++) begin
            @(posedge clk);
            if (rsp.ack === 1'b1) break;
        end
        req <= '0;
        if (k == 64) stop();
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] ix, input logic [31:0] e);
        rq.push_back(e);
        wb(ix, 1'b0, 8'h00);
    endtask
    task automatic ev(input int k);
        repeat (k) @(negedge smp);
        @(posedge clk);
    endtask
    task automatic expect_smp(input logic [10:0] e);
        int i;
        repeat (4) sq.push_back(e);
        for (i = 0; i < 400 && sq.size() > 0; i++) @(posedge clk);
        if (sq.size() > 0) stop();
    endtask
    task automatic pat(input logic [7:0] c, input logic [7:0] pc, input logic [7:0] pb, input logic [10:0] e);
        wb(`ADCB_IDX_CTRL, 1'b1, c);
        wb(`ADCB_IDX_PAT_COM, 1'b1, pc);
        wb(`ADCB_IDX_PAT_B, 1'b1, pb);
        ev(34);
        expect_smp(e);
    endtask
    task automatic ofs(input logic [2:0] pd, input logic [10:0] e);
        wb(`ADCB_IDX_PED_B, 1'b1, {2'h0, pd, 3'h0});
        ev(120);
        expect_smp(e);
    endtask
    always @(posedge clk) begin
        if (rsp.ack === 1'b1 && req.we === 1'b0 && rq.size() > 0) chk_reg("read data", rq.pop_front(), rsp.dat);
        if (cv === 1'b1 && sq.size() > 0) chk_smp(sq.pop_front(), cd);
    end
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        req = '0;
        lf = 16'h002f;
        code = 11'h000;
        mismatches = 0;
        checked = 0;
        ix_t = '{`ADCB_IDX_CTRL, `ADCB_IDX_PAT_B, `ADCB_IDX_PED_B, `ADCB_IDX_STAT, 8'h7f};
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (ix_t[i]) rd(ix_t[i], 32'h0);
        lf = nx(lf);
        a = lf[10:0];
        code <= a;
        wb(`ADCB_IDX_CUST_LO, 1'b1, lf[7:0]);
        wb(`ADCB_IDX_CUST_HI, 1'b1, lf[15:8]);
        rd(`ADCB_IDX_CUST_HI, {24'h0, lf[15:8]});
        pat(8'h01, 8'h00, 8'h01, 11'h000);
        pat(8'h01, 8'h00, 8'h02, 11'h7ff);
        pat(8'h00, 8'h02, 8'h01, 11'h7ff);
        pat(8'h03, 8'h00, 8'h05, {lf[15:8], lf[7:5]});
        chk_smp({10'h000, lf[4]}, {10'h000, so.word[0]});
        for (n = 0; n < 64 && so.clk !== 1'b1; n++) @(posedge clk);
        if (n == 64) stop();
        chk_smp({5'h00, lf[14], lf[12], lf[10], lf[8], lf[6], lf[4]}, {5'h00, so.ddr_half});
        for (n = 0; n < 64 && so.clk !== 1'b0; n++) @(posedge clk);
        if (n == 64) stop();
        chk_smp({5'h00, lf[15], lf[13], lf[11], lf[9], lf[7], lf[5]}, {5'h00, so.ddr_half});
        pat(8'h01, 8'h00, 8'h06, a);
        wb(`ADCB_IDX_PAT_B, 1'b1, 8'h03);
        ev(150);
        wb(`ADCB_IDX_PAT_B, 1'b1, 8'h04);
        ev(300);
        wb(`ADCB_IDX_PAT_B, 1'b1, 8'h00);
        ev(34);
        b = a ^ 11'h555;
        while (smp) @(posedge clk);
        while (!smp) @(posedge clk);
        code <= b;
        sp = 1'b1;
        f = 0;
        for (n = 0; n < 400 && so.word[11:1] !== b; n++) begin
            @(posedge clk);
            if (sp && !smp) f++;
            sp = smp;
        end
        if (n == 400) stop();
        chk_reg("latency", `ADCB_LATENCY + 1, f);
        wb(`ADCB_IDX_CTRL, 1'b1, 8'h05);
        ev(34);
        expect_smp(b ^ 11'h400);
        lf = nx(lf);
        code <= 11'h400 + {5'h00, lf[5:0]};
        wb(`ADCB_IDX_CTRL, 1'b1, 8'h01);
        wb(`ADCB_IDX_OFS_EN_B, 1'b1, 8'h40);
        ofs(3'h3, 11'h403);
        ofs(3'h4, 11'h3fc);
        wb(`ADCB_IDX_OFS_EN_B, 1'b1, 8'h00);
        code <= code + 11'h005;
        ev(34);
        expect_smp(11'h401);
        final_report();
    end
endmodule
`default_nettype wire
